// ==== core/pib_regs.vh ====
`ifndef PIB_REGS_VH
`define PIB_REGS_VH

// register byte addresses
`define PIB_ADDR_CONTROL   8'h00
`define PIB_ADDR_ENABLE_1  8'h04
`define PIB_ADDR_ENABLE_2  8'h08
`define PIB_ADDR_FLAGS_1   8'h0C
`define PIB_ADDR_FLAGS_2   8'h10
`define PIB_ADDR_STATUS    8'h14
`define PIB_ADDR_MASK      8'h18

// control register fields
`define PIB_CTRL_GLOBAL_BIT 7
`define PIB_CTRL_GROUP_BIT  6
`define PIB_CTRL_MASK       8'hC0

// first flag register fields
`define PIB_F1_TIMER1_GATE  7
`define PIB_F1_CONVERTER    6
`define PIB_F1_RECEIVE      5
`define PIB_F1_TRANSMIT     4
`define PIB_F1_SYNC_SERIAL  3
`define PIB_F1_CAPTURE      2
`define PIB_F1_TIMER2_MATCH 1
`define PIB_F1_TIMER1_OVF   0
`define PIB_F1_RO_MASK      8'h30
`define PIB_F1_IMPL_MASK    8'hFF

// second enable / flag register fields
`define PIB_F2_OSC_FAIL     7
`define PIB_F2_COMPARATOR   5
`define PIB_F2_NVM_DONE     4
`define PIB_F2_COLLISION    3
`define PIB_F2_IMPL_MASK    8'hB8

// event status fields (write one to clear)
`define PIB_ST_REQ_RISE     0
`define PIB_ST_OVERRUN      1
`define PIB_ST_RO_WRITE     2
`define PIB_ST_IMPL_MASK    8'h07

// reset values
`define PIB_RESET_BYTE      8'h00
`define PIB_RESET_WORD      32'h00000000

`endif

// ==== core/pib_flag_reg.v ====
`timescale 1ns/1ns
// pending-flag register: hardware set beats a software clear in the same cycle
module pib_flag_reg #(
   parameter              WIDTH     = 8,
   parameter [WIDTH-1:0]  IMPL_MASK = {WIDTH{1'b1}},
   parameter [WIDTH-1:0]  RO_MASK   = {WIDTH{1'b0}}
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] set_i,
   input  wire [WIDTH-1:0] level_i,
   input  wire             wr_i,
   input  wire [WIDTH-1:0] wdata_i,
   output wire [WIDTH-1:0] flags_o,
   output wire [WIDTH-1:0] overrun_o
);
   localparam [WIDTH-1:0] RW_MASK = IMPL_MASK & ~RO_MASK;

   reg [WIDTH-1:0] flags_reg;
   reg [WIDTH-1:0] flags_next;

   always @* begin
      flags_next = flags_reg;
      if (wr_i) begin
         flags_next = (wdata_i & RW_MASK) | (flags_reg & ~RW_MASK);
      end
      flags_next = (flags_next | (set_i & RW_MASK)) & RW_MASK;
      // read-only flags mirror the source's own level, cleared by the source
      flags_next = flags_next | (level_i & RO_MASK & IMPL_MASK);
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         flags_reg <= {WIDTH{1'b0}};
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags_o   = flags_reg;
   assign overrun_o = set_i & flags_reg & RW_MASK;
endmodule // pib_flag_reg

// ==== core/pib_top.v ====
`timescale 1ns/1ns
`include "pib_regs.vh"
module pib_top #(
   parameter ADR_W = 8
) (
   input  wire             clk_i,
   input  wire             rst_i,
   // classic wishbone slave
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [ADR_W-1:0] wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output wire [31:0]      wb_dat_o,
   output wire             wb_ack_o,
   // one-cycle event pulses from peripherals on this clock
   input  wire             timer1_gate_evt_i,
   input  wire             converter_evt_i,
   input  wire             sync_serial_evt_i,
   input  wire             capture_compare_evt_i,
   input  wire             timer2_match_evt_i,
   input  wire             timer1_overflow_evt_i,
   input  wire             osc_fail_evt_i,
   input  wire             comparator_evt_i,
   input  wire             nvm_write_done_evt_i,
   input  wire             bus_collision_evt_i,
   // levels held by the serial unit until it is serviced
   input  wire             serial_receive_lvl_i,
   input  wire             serial_transmit_lvl_i,
   // requests toward the processor core
   output wire             periph_irq_req_o,
   output wire             core_irq_req_o,
   output wire             irq_o
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   reg  [7:0]  irq_control_reg;
   reg  [7:0]  periph_irq_enable_1_reg;
   reg  [7:0]  periph_irq_enable_2_reg;
   reg  [7:0]  event_status_reg;
   reg  [7:0]  event_mask_reg;
   reg  [7:0]  event_status_next;
   reg         ack_reg;
   reg  [31:0] rdata_reg;
   reg  [31:0] rdata_next;
   reg         periph_req_reg;
   reg         core_req_reg;
   reg         irq_reg;
   reg         periph_req_prev_reg;

   wire [7:0]  periph_irq_flags_1;
   wire [7:0]  periph_irq_flags_2;
   wire [7:0]  overrun_1;
   wire [7:0]  overrun_2;
   wire [7:0]  set_1;
   wire [7:0]  set_2;
   wire [7:0]  level_1;
   wire [7:0]  level_2;

   wire        periph_group_enable;
   wire        global_irq_enable;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire        bus_req;
   wire        bus_wr;
   wire        bus_rd;
   wire        lane0;
   wire [7:0]  wbyte;

   reg         hit_ctrl;
   reg         hit_en1;
   reg         hit_en2;
   reg         hit_fl1;
   reg         hit_fl2;
   reg         hit_st;
   reg         hit_mask;

   // the access is answered one cycle after it is seen, then ack drops
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign lane0   = wb_sel_i[0];
   assign bus_wr  = bus_req & wb_we_i & lane0;
   assign bus_rd  = bus_req & ~wb_we_i;
   assign wbyte   = wb_dat_i[7:0];

   always @* begin
      hit_ctrl = 1'b0;
      hit_en1  = 1'b0;
      hit_en2  = 1'b0;
      hit_fl1  = 1'b0;
      hit_fl2  = 1'b0;
      hit_st   = 1'b0;
      hit_mask = 1'b0;
      if (wb_adr_i == `PIB_ADDR_CONTROL) begin
         hit_ctrl = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_ENABLE_1) begin
         hit_en1 = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_ENABLE_2) begin
         hit_en2 = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_FLAGS_1) begin
         hit_fl1 = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_FLAGS_2) begin
         hit_fl2 = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_STATUS) begin
         hit_st = 1'b1;
      end else if (wb_adr_i == `PIB_ADDR_MASK) begin
         hit_mask = 1'b1;
      end
   end

   wire wr_ctrl = bus_wr & hit_ctrl;
   wire wr_en1  = bus_wr & hit_en1;
   wire wr_en2  = bus_wr & hit_en2;
   wire wr_fl1  = bus_wr & hit_fl1;
   wire wr_fl2  = bus_wr & hit_fl2;
   wire wr_st   = bus_wr & hit_st;
   wire wr_mask = bus_wr & hit_mask;

   // ---------------------------------------------------------------
   // control and enable registers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_control_reg         <= `PIB_RESET_BYTE;
         periph_irq_enable_1_reg <= `PIB_RESET_BYTE;
         periph_irq_enable_2_reg <= `PIB_RESET_BYTE;
         event_mask_reg          <= `PIB_RESET_BYTE;
      end else begin
         if (wr_ctrl) begin
            irq_control_reg <= wbyte & `PIB_CTRL_MASK;
         end
         if (wr_en1) begin
            periph_irq_enable_1_reg <= wbyte;
         end
         if (wr_en2) begin
            periph_irq_enable_2_reg <= wbyte & `PIB_F2_IMPL_MASK;
         end
         if (wr_mask) begin
            event_mask_reg <= wbyte & `PIB_ST_IMPL_MASK;
         end
      end
   end

   assign periph_group_enable = irq_control_reg[`PIB_CTRL_GROUP_BIT];
   assign global_irq_enable   = irq_control_reg[`PIB_CTRL_GLOBAL_BIT];

   // ---------------------------------------------------------------
   // request flags
   // ---------------------------------------------------------------
   assign set_1[`PIB_F1_TIMER1_GATE]  = timer1_gate_evt_i;
   assign set_1[`PIB_F1_CONVERTER]    = converter_evt_i;
   assign set_1[`PIB_F1_RECEIVE]      = 1'b0;
   assign set_1[`PIB_F1_TRANSMIT]     = 1'b0;
   assign set_1[`PIB_F1_SYNC_SERIAL]  = sync_serial_evt_i;
   assign set_1[`PIB_F1_CAPTURE]      = capture_compare_evt_i;
   assign set_1[`PIB_F1_TIMER2_MATCH] = timer2_match_evt_i;
   assign set_1[`PIB_F1_TIMER1_OVF]   = timer1_overflow_evt_i;

   assign level_1 = {2'b00, serial_receive_lvl_i, serial_transmit_lvl_i, 4'h0};

   assign set_2[`PIB_F2_OSC_FAIL]   = osc_fail_evt_i;
   assign set_2[6]                  = 1'b0;
   assign set_2[`PIB_F2_COMPARATOR] = comparator_evt_i;
   assign set_2[`PIB_F2_NVM_DONE]   = nvm_write_done_evt_i;
   assign set_2[`PIB_F2_COLLISION]  = bus_collision_evt_i;
   assign set_2[2:0]                = 3'b000;

   assign level_2 = 8'h00;

   pib_flag_reg #(
      .WIDTH     (8),
      .IMPL_MASK (`PIB_F1_IMPL_MASK),
      .RO_MASK   (`PIB_F1_RO_MASK)
   ) u_flags_1 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .set_i     (set_1),
      .level_i   (level_1),
      .wr_i      (wr_fl1),
      .wdata_i   (wbyte),
      .flags_o   (periph_irq_flags_1),
      .overrun_o (overrun_1)
   );

   pib_flag_reg #(
      .WIDTH     (8),
      .IMPL_MASK (`PIB_F2_IMPL_MASK),
      .RO_MASK   (8'h00)
   ) u_flags_2 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .set_i     (set_2),
      .level_i   (level_2),
      .wr_i      (wr_fl2),
      .wdata_i   (wbyte),
      .flags_o   (periph_irq_flags_2),
      .overrun_o (overrun_2)
   );

   // ---------------------------------------------------------------
   // request combining
   // ---------------------------------------------------------------
   wire [15:0] pend_all;
   wire [15:0] en_all;
   wire [15:0] active;

   assign pend_all = {periph_irq_flags_2, periph_irq_flags_1};
   assign en_all   = {periph_irq_enable_2_reg, periph_irq_enable_1_reg};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_gate
         assign active[gi] = pend_all[gi] & en_all[gi];
      end
   endgenerate

   wire periph_req_next = (|active) & periph_group_enable;
   wire core_req_next   = periph_req_next & global_irq_enable;

   // ---------------------------------------------------------------
   // event status (write one to clear, set wins)
   // ---------------------------------------------------------------
   wire [7:0] evt_set;
   wire       ro_write;

   // a write that tries to raise a read-only serial flag is worth flagging
   assign ro_write = wr_fl1 & (|(wbyte & `PIB_F1_RO_MASK));

   assign evt_set[`PIB_ST_REQ_RISE] = periph_req_reg & ~periph_req_prev_reg;
   assign evt_set[`PIB_ST_OVERRUN]  = (|overrun_1) | (|overrun_2);
   assign evt_set[`PIB_ST_RO_WRITE] = ro_write;
   assign evt_set[7:3]              = 5'b00000;

   always @* begin
      event_status_next = event_status_reg;
      if (wr_st) begin
         event_status_next = event_status_reg & ~wbyte;
      end
      event_status_next = (event_status_next | evt_set) & `PIB_ST_IMPL_MASK;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         event_status_reg    <= `PIB_RESET_BYTE;
         periph_req_reg      <= 1'b0;
         periph_req_prev_reg <= 1'b0;
         core_req_reg        <= 1'b0;
         irq_reg             <= 1'b0;
      end else begin
         event_status_reg    <= event_status_next;
         periph_req_reg      <= periph_req_next;
         periph_req_prev_reg <= periph_req_reg;
         core_req_reg        <= core_req_next;
         irq_reg             <= |(event_status_next & event_mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // read path and acknowledge
   // ---------------------------------------------------------------
   always @* begin
      rdata_next = `PIB_RESET_WORD;
      if (hit_ctrl) begin
         rdata_next[7:0] = irq_control_reg;
      end else if (hit_en1) begin
         rdata_next[7:0] = periph_irq_enable_1_reg;
      end else if (hit_en2) begin
         rdata_next[7:0] = periph_irq_enable_2_reg & `PIB_F2_IMPL_MASK;
      end else if (hit_fl1) begin
         rdata_next[7:0] = periph_irq_flags_1;
      end else if (hit_fl2) begin
         rdata_next[7:0] = periph_irq_flags_2 & `PIB_F2_IMPL_MASK;
      end else if (hit_st) begin
         rdata_next[7:0] = event_status_reg;
      end else if (hit_mask) begin
         rdata_next[7:0] = event_mask_reg;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg   <= 1'b0;
         rdata_reg <= `PIB_RESET_WORD;
      end else begin
         ack_reg <= bus_req;
         // unmapped addresses still ack, reading zero, so a stray access never hangs
         if (bus_rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign wb_ack_o         = ack_reg;
   assign wb_dat_o         = rdata_reg;
   assign periph_irq_req_o = periph_req_reg;
   assign core_irq_req_o   = core_req_reg;
   assign irq_o            = irq_reg;
endmodule // pib_top

// ==== dv/pib_sva.sv ====
`timescale 1ns/1ns
module pib_sva #(
   parameter ADR_W = 8
) (
   input logic             clk_i,
   input logic             rst_i,
   input logic             wb_cyc_i,
   input logic             wb_stb_i,
   input logic             wb_we_i,
   input logic [ADR_W-1:0] wb_adr_i,
   input logic [3:0]       wb_sel_i,
   input logic [31:0]      wb_dat_i,
   input logic [31:0]      wb_dat_o,
   input logic             wb_ack_o,
   input logic             periph_irq_req_o,
   input logic             core_irq_req_o,
   input logic             irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic       grp_reg;
   logic       gie_reg;
   logic [2:0] mask_reg;
   logic       wr;
   // shadow copies of the enables, updated on the edge that takes the write
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   always @(posedge clk_i) begin
      if (rst_i) begin
         grp_reg  <= 1'b0;
         gie_reg  <= 1'b0;
         mask_reg <= 3'h0;
      end else if (wr && wb_adr_i == 8'h00) begin
         {gie_reg, grp_reg} <= wb_dat_i[7:6];
      end else if (wr && wb_adr_i == 8'h18) begin
         mask_reg <= wb_dat_i[2:0];
      end
   end
   property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rst_clear; $fell(rst_i) |-> !wb_ack_o && !periph_irq_req_o && !core_irq_req_o && !irq_o; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
   property p_grp_off; !grp_reg |=> !periph_irq_req_o; endproperty
   a_grp_off: assert property (p_grp_off) else $error("request with group enable off");
   property p_gie_off; !gie_reg |=> !core_irq_req_o; endproperty
   a_gie_off: assert property (p_gie_off) else $error("core request with global enable off");
   property p_mask_off; (mask_reg == 3'h0) [*2] |-> !irq_o; endproperty
   a_mask_off: assert property (p_mask_off) else $error("interrupt with mask clear");
   property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
   property p_unimpl;
      wb_ack_o && !wb_we_i && (wb_adr_i == 8'h08 || wb_adr_i == 8'h10) |-> (wb_dat_o[7:0] & 8'h47) == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");
endmodule // pib_sva
bind pib_top pib_sva #(.ADR_W(ADR_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_irq_req_o(periph_irq_req_o),
   .core_irq_req_o(core_irq_req_o), .irq_o(irq_o));

// ==== dv/pib_periph_model.sv ====
`timescale 1ns/1ns
// peripherals: events leave as one-cycle pulses, serial levels stay until serviced
module pib_periph_model (
   input  logic       clk_i,
   input  logic [9:0] fire_i,
   input  logic [1:0] hold_i,
   output logic [9:0] evt_o = 10'h000,
   output logic [1:0] lvl_o = 2'h0
);
   always @(posedge clk_i) begin
      evt_o <= fire_i;
      lvl_o <= hold_i;
   end
endmodule // pib_periph_model

// ==== dv/test_peripheral_irq_enable_flag_bank.sv ====
`timescale 1ns/1ns
module test_peripheral_irq_enable_flag_bank;
   logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, periph_irq_req_o, core_irq_req_o, irq_o;
   logic [9:0]  fire = 10'h000, evt;
   logic [1:0]  hold = 2'h0, lvl;
   logic [7:0]  exp_q[$];
   logic [7:0]  m;
   logic [7:0]  one_hot[4] = '{8'h80, 8'h20, 8'h10, 8'h08};
   logic [31:0] r = 32'h377F;
   int          failures = 0, comparisons = 0;
   pib_periph_model u_pm (.clk_i(clk_i), .fire_i(fire), .hold_i(hold), .evt_o(evt), .lvl_o(lvl));
   pib_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .timer1_gate_evt_i(evt[9]), .converter_evt_i(evt[8]), .sync_serial_evt_i(evt[7]),
      .capture_compare_evt_i(evt[6]), .timer2_match_evt_i(evt[5]), .timer1_overflow_evt_i(evt[4]),
      .osc_fail_evt_i(evt[3]), .comparator_evt_i(evt[2]), .nvm_write_done_evt_i(evt[1]),
      .bus_collision_evt_i(evt[0]), .serial_receive_lvl_i(lvl[1]), .serial_transmit_lvl_i(lvl[0]),
      .periph_irq_req_o(periph_irq_req_o), .core_irq_req_o(core_irq_req_o), .irq_o(irq_o));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      if (g !== e) begin
         $display("ERROR %0t got %h expected %h", $time, g, e);
         failures++;
      end
      comparisons++;
   endtask
   // for a read, d is the expected byte; the monitor compares it when ack shows
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      if (!w) exp_q.push_back(d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, w, a, 4'h1};
      wb_dat_i <= {24'h000000, w ? d : 8'h00};
      // no cycle count is assumed here; only the watchdog ends a wait
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic outs(input logic [2:0] e);
      @(posedge clk_i);
      chk({5'h00, periph_irq_req_o, core_irq_req_o, irq_o}, {5'h00, e});
   endtask
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk(wb_dat_o[7:0], exp_q.pop_front());
   end
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      $display("ERROR %0t watchdog expired", $time);
      failures++;
      stop_test;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a <= 28; a += 4) bus(0, 8'(a), 8'h00);
      bus(1, 8'h08, 8'hFF);
      bus(0, 8'h08, 8'hB8);
      bus(1, 8'h10, 8'hFF);
      bus(0, 8'h10, 8'hB8);
      bus(1, 8'h0C, 8'hFF);
      bus(0, 8'h0C, 8'hCF);
      bus(1, 8'h08, 8'h00);
      bus(1, 8'h10, 8'h00);
      bus(1, 8'h0C, 8'h00);
      for (int i = 0; i < 6; i++) begin
         r = xs(r);
         @(posedge clk_i);
         fire <= r[9:0];
         hold <= r[11:10];
         @(posedge clk_i);
         fire <= 10'h000;
         bus(0, 8'h0C, {r[9:8], r[11:10], r[7:4]});
         bus(0, 8'h10, {r[3], 1'b0, r[2:0], 3'h0});
         bus(1, 8'h0C, 8'h00);
         bus(1, 8'h10, 8'h00);
      end
      hold <= 2'h0;
      bus(0, 8'h14, 8'h04);
      bus(1, 8'h14, 8'h07);
      foreach (one_hot[k]) begin
         m = one_hot[k];
         bus(1, 8'h00, 8'h40);
         bus(1, 8'h10, m);
         bus(1, 8'h08, 8'hB8 ^ m);
         outs(3'b000);
         bus(1, 8'h08, m);
         outs(3'b100);
         bus(1, 8'h00, 8'h80);
         outs(3'b000);
         bus(1, 8'h00, 8'hC0);
         outs(3'b110);
         bus(1, 8'h08, 8'h00);
         bus(1, 8'h10, 8'h00);
      end
      bus(1, 8'h00, 8'h40);
      bus(1, 8'h04, 8'h01);
      fire <= 10'h010;
      @(posedge clk_i);
      fire <= 10'h000;
      repeat (2) @(posedge clk_i);
      outs(3'b100);
      // a second event on the still-pending flag must raise the overrun status
      fire <= 10'h010;
      @(posedge clk_i);
      fire <= 10'h000;
      repeat (2) @(posedge clk_i);
      bus(1, 8'h0C, 8'h00);
      bus(0, 8'h14, 8'h03);
      bus(1, 8'h18, 8'h01);
      outs(3'b001);
      bus(1, 8'h14, 8'h01);
      outs(3'b000);
      bus(1, 8'h00, 8'hC0);
      bus(1, 8'h08, 8'hB8);
      bus(1, 8'h10, 8'hB8);
      outs(3'b110);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      outs(3'b000);
      for (int a = 0; a <= 16; a += 4) bus(0, 8'(a), 8'h00);
      repeat (3) @(posedge clk_i);
      stop_test;
   end
endmodule // test_peripheral_irq_enable_flag_bank
